//--- hw/stepper_pkg.sv
// Shared constants for the stepper phase input control block.
package stepper_pkg;

    // Register byte offsets on the bus.
    localparam int ADDR_W = 8;
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_IRQ_STATUS = 8'h08;
    localparam logic [7:0] REG_IRQ_MASK = 8'h0c;

    // Control register fields and reset value.
    localparam int CTRL_DRIVE_OFF_BIT = 0;
    localparam logic CTRL_DRIVE_OFF_RESET = 1'h0;

    // Status register fields.
    localparam int ST_DRIVE_LSB = 0;
    localparam int ST_OC_BIT = 4;
    localparam int ST_OH_BIT = 5;
    localparam int ST_ENABLE_BIT = 6;
    localparam int ST_INIT_BIT = 7;
    localparam int ST_RUN_BIT = 8;
    localparam int ST_FAULT_BIT = 9;

    // Interrupt events, one status and one mask bit each.
    localparam int EV_OC = 0;
    localparam int EV_OH = 1;
    localparam int EV_CLASH = 2;
    localparam int EV_INIT = 3;
    localparam int EV_COUNT = 4;
    localparam logic [3:0] IRQ_MASK_RESET = 4'h0;

    // Phase order inside every four-bit phase vector.
    localparam int PH_A = 0;
    localparam int PH_AB = 1;
    localparam int PH_B = 2;
    localparam int PH_BB = 3;
    localparam logic [3:0] INIT_EXCITE = 4'h9;
    localparam logic [3:0] PHASES_OFF = 4'h0;

    // Overcurrent blanking after each PWM cycle start.
    localparam int BLANK_TIME_NS = 5500;
    localparam int MCLK_PERIOD_NS = 25;
    localparam int BLANK_CYCLES = (BLANK_TIME_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
    localparam int BLANK_CNT_W = 8;
    localparam logic [7:0] BLANK_LIMIT = 8'(BLANK_CYCLES);

    // Drive state, one-hot.
    typedef enum logic [2:0] {
        ST_INIT = 3'h1,
        ST_RUN = 3'h2,
        ST_FAULT = 3'h4
    } drive_state_t;

endpackage

//--- hw/stepper_oc_blank.sv
// Overcurrent blanking window timer restarted at every PWM cycle.
`timescale 1ns/1ps
`default_nettype none
module stepper_oc_blank
    import stepper_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic run,
    input wire logic cycle_start,
    output logic window_open
);

    logic [7:0] count_reg;

    // Counts from each cycle start; frozen while the internal clock is stopped.
    always_ff @(posedge mclk) begin
        if (rst || (run && cycle_start)) begin
            count_reg <= 8'h00;
        end else if (run && count_reg != BLANK_LIMIT) begin
            count_reg <= count_reg + 8'h01;
        end
    end

    // Detection only counts once the ringing interval is over.
    assign window_open = (count_reg == BLANK_LIMIT);

    a_blank_restart: assert property (@(posedge mclk) disable iff (rst)
        (run && cycle_start) |=> !window_open [*8])
        else $error("overcurrent window opened too early");

endmodule
`default_nettype wire

//--- hw/stepper_irq_unit.sv
// Sticky interrupt status with write-one-to-clear and a mask.
`timescale 1ns/1ps
`default_nettype none
module stepper_irq_unit
    import stepper_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic [EV_COUNT-1:0] event_hit,
    input wire logic [EV_COUNT-1:0] clear_req,
    input wire logic [EV_COUNT-1:0] mask,
    output logic [EV_COUNT-1:0] status,
    output logic irq
);

    genvar i;
    // A set arriving with a clear wins so no event is lost.
    generate
        for (i = 0; i < EV_COUNT; i++) begin : g_bit
            always_ff @(posedge mclk) begin
                if (rst) begin
                    status[i] <= 1'b0;
                end else if (event_hit[i]) begin
                    status[i] <= 1'b1;
                end else if (clear_req[i]) begin
                    status[i] <= 1'b0;
                end
            end

            a_set_wins: assert property (@(posedge mclk) disable iff (rst)
                (event_hit[i] && clear_req[i]) |=> status[i])
                else $error("interrupt event lost against clear");
        end
    endgenerate

    // Level output, high while any unmasked bit stands.
    assign irq = |(status & mask);

endmodule
`default_nettype wire

//--- hw/stepper_phase_input_control.sv
// Phase input control of a two-phase unipolar stepper driver with bus registers.
//
// Added by the designer: register access over Wishbone and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module stepper_phase_input_control
    import stepper_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic system_reset_n_pin,
    input wire logic enable_pin,
    input wire logic phase_a_n_pin,
    input wire logic phase_ab_n_pin,
    input wire logic phase_b_n_pin,
    input wire logic phase_bb_n_pin,
    input wire logic overcurrent_det,
    input wire logic overheat_det,
    input wire logic pwm_cycle_start,
    output logic drive_a,
    output logic drive_ab,
    output logic drive_b,
    output logic drive_bb,
    output logic fault_n_o,
    output logic fault_n_oe,
    output logic irq
);

    logic core_rst;
    logic core_rst_d_reg;
    logic [3:0] phase_req;
    logic [3:0] prev_req_reg;
    logic [3:0] phase_safe;
    logic clash_a;
    logic clash_b;
    logic blank_open;
    logic oc_hit;
    logic oh_hit;
    logic fault_hit;
    logic req_changed;
    drive_state_t state_reg;
    drive_state_t state_next;
    logic [3:0] excite_reg;
    logic [3:0] drive_reg;
    logic oc_latch_reg;
    logic oh_latch_reg;
    logic ctrl_drive_off_reg;
    logic [EV_COUNT-1:0] irq_mask_reg;
    logic [EV_COUNT-1:0] irq_status;
    logic [EV_COUNT-1:0] irq_event;
    logic [EV_COUNT-1:0] irq_clear;
    logic ack_reg;
    logic [31:0] rdata_reg;
    logic bus_req;
    logic wr_fire;
    logic [31:0] rd_mux;

    // Either the power-on reset or a low system reset pin resets the core.
    assign core_rst = rst || !system_reset_n_pin;

    // Inputs are active low; bit order follows the phase index constants.
    assign phase_req[PH_A] = !phase_a_n_pin;
    assign phase_req[PH_AB] = !phase_ab_n_pin;
    assign phase_req[PH_B] = !phase_b_n_pin;
    assign phase_req[PH_BB] = !phase_bb_n_pin;

    // A clashing pair drops both phases rather than guessing which one wins.
    assign clash_a = phase_req[PH_A] && phase_req[PH_AB];
    assign clash_b = phase_req[PH_B] && phase_req[PH_BB];
    assign phase_safe = phase_req & ~{clash_b, clash_b, clash_a, clash_a};

    // Overcurrent only counts outside the blanking interval.
    stepper_oc_blank u_blank (
        .mclk(mclk),
        .rst(core_rst),
        .run(enable_pin),
        .cycle_start(pwm_cycle_start),
        .window_open(blank_open)
    );

    // Detectors are looked at only while the internal clock runs.
    assign oc_hit = enable_pin && overcurrent_det && blank_open;
    assign oh_hit = enable_pin && overheat_det;
    assign fault_hit = oc_hit || oh_hit;
    assign req_changed = (phase_req != prev_req_reg);

    // Previous request, used to see the first phase change after reset.
    always_ff @(posedge mclk) begin
        if (core_rst) begin
            prev_req_reg <= phase_req;
        end else if (enable_pin) begin
            prev_req_reg <= phase_req;
        end
    end

    // Next drive state; a fault always takes priority over a phase change.
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            ST_INIT: begin
                if (fault_hit) begin
                    state_next = ST_FAULT;
                end else if (enable_pin && req_changed) begin
                    state_next = ST_RUN;
                end
            end
            ST_RUN: begin
                if (fault_hit) begin
                    state_next = ST_FAULT;
                end
            end
            ST_FAULT: begin
                state_next = ST_FAULT;
            end
            default: begin
                state_next = ST_FAULT;
            end
        endcase
    end

    // State register; holds while enable is low, as the clock would be stopped.
    always_ff @(posedge mclk) begin
        if (core_rst) begin
            state_reg <= ST_INIT;
        end else if (enable_pin) begin
            state_reg <= state_next;
        end
    end

    // Excitation pattern; the reset value is the starting A plus BB pattern.
    always_ff @(posedge mclk) begin
        if (core_rst) begin
            excite_reg <= INIT_EXCITE;
        end else if (enable_pin && state_next == ST_RUN) begin
            excite_reg <= phase_safe;
        end
    end

    // Fault latches; cleared only by power-on or system reset.
    always_ff @(posedge mclk) begin
        if (core_rst) begin
            oc_latch_reg <= 1'b0;
            oh_latch_reg <= 1'b0;
        end else begin
            if (oc_hit) begin
                oc_latch_reg <= 1'b1;
            end
            if (oh_hit) begin
                oh_latch_reg <= 1'b1;
            end
        end
    end

    // Output stage; a fresh fault cuts drive in the same edge that latches it.
    always_ff @(posedge mclk) begin
        if (core_rst) begin
            drive_reg <= PHASES_OFF;
        end else if (!enable_pin || ctrl_drive_off_reg) begin
            drive_reg <= PHASES_OFF;
        end else if (fault_hit || state_reg == ST_FAULT) begin
            drive_reg <= PHASES_OFF;
        end else begin
            drive_reg <= excite_reg;
        end
    end

    assign drive_a = drive_reg[PH_A];
    assign drive_ab = drive_reg[PH_AB];
    assign drive_b = drive_reg[PH_B];
    assign drive_bb = drive_reg[PH_BB];

    // Open-drain fault pin: only ever pulled low, enabled while a latch stands.
    assign fault_n_o = 1'b0;
    assign fault_n_oe = oc_latch_reg || oh_latch_reg;

    // Delayed core reset, used to mark the release of reset as an event.
    always_ff @(posedge mclk) begin
        if (rst) begin
            core_rst_d_reg <= 1'b1;
        end else begin
            core_rst_d_reg <= core_rst;
        end
    end

    // Wishbone classic slave: ack one cycle after the request, dropped after.
    // Writes land at the ack edge, so a master that gives up before ack changes nothing.
    assign bus_req = wb_cyc_i && wb_stb_i;
    assign wr_fire = bus_req && wb_we_i && ack_reg;

    always_ff @(posedge mclk) begin
        if (rst) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= bus_req && !ack_reg;
        end
    end

    // Register writes; only byte lane 0 holds writable bits.
    always_ff @(posedge mclk) begin
        if (rst) begin
            ctrl_drive_off_reg <= CTRL_DRIVE_OFF_RESET;
            irq_mask_reg <= IRQ_MASK_RESET;
        end else if (wr_fire && wb_sel_i[0]) begin
            if (wb_adr_i == REG_CTRL) begin
                ctrl_drive_off_reg <= wb_dat_i[CTRL_DRIVE_OFF_BIT];
            end
            if (wb_adr_i == REG_IRQ_MASK) begin
                irq_mask_reg <= wb_dat_i[EV_COUNT-1:0];
            end
        end
    end

    // Read mux; unmapped addresses read as zero and still acknowledge.
    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (wb_adr_i)
            REG_CTRL: begin
                rd_mux[CTRL_DRIVE_OFF_BIT] = ctrl_drive_off_reg;
            end
            REG_STATUS: begin
                rd_mux[ST_DRIVE_LSB +: 4] = drive_reg;
                rd_mux[ST_OC_BIT] = oc_latch_reg;
                rd_mux[ST_OH_BIT] = oh_latch_reg;
                rd_mux[ST_ENABLE_BIT] = enable_pin;
                rd_mux[ST_INIT_BIT] = (state_reg == ST_INIT);
                rd_mux[ST_RUN_BIT] = (state_reg == ST_RUN);
                rd_mux[ST_FAULT_BIT] = (state_reg == ST_FAULT);
            end
            REG_IRQ_STATUS: begin
                rd_mux[EV_COUNT-1:0] = irq_status;
            end
            REG_IRQ_MASK: begin
                rd_mux[EV_COUNT-1:0] = irq_mask_reg;
            end
            default: begin
                rd_mux = 32'h0000_0000;
            end
        endcase
    end

    // Read data is captured with the request so it stands with ack.
    always_ff @(posedge mclk) begin
        if (rst) begin
            rdata_reg <= 32'h0000_0000;
        end else if (bus_req && !ack_reg) begin
            rdata_reg <= rd_mux;
        end
    end

    assign wb_ack_o = ack_reg;
    assign wb_dat_o = rdata_reg;

    // Interrupt events: new latches, a refused phase pair, reset release.
    assign irq_event[EV_OC] = oc_hit && !oc_latch_reg && !core_rst;
    assign irq_event[EV_OH] = oh_hit && !oh_latch_reg && !core_rst;
    assign irq_event[EV_CLASH] = enable_pin && !core_rst && (clash_a || clash_b);
    assign irq_event[EV_INIT] = core_rst_d_reg && !core_rst;
    assign irq_clear = (wr_fire && wb_sel_i[0] && wb_adr_i == REG_IRQ_STATUS)
        ? wb_dat_i[EV_COUNT-1:0] : 4'h0;

    stepper_irq_unit u_irq (
        .mclk(mclk),
        .rst(rst),
        .event_hit(irq_event),
        .clear_req(irq_clear),
        .mask(irq_mask_reg),
        .status(irq_status),
        .irq(irq)
    );

    // Checks on the drive outputs and fault path.
    a_pair_exclusive: assert property (@(posedge mclk) disable iff (rst)
        !(drive_a && drive_ab) && !(drive_b && drive_bb))
        else $error("complementary phases energised together");

    a_phase_mapping: assert property (@(posedge mclk) disable iff (core_rst)
        ($past(state_reg == ST_RUN) && $past(enable_pin) && $past(enable_pin, 2)
            && drive_a) |-> $past(!phase_a_n_pin, 2))
        else $error("phase A driven without its low input");

    a_active_low: assert property (@(posedge mclk) disable iff (core_rst)
        ($past(state_reg == ST_RUN) && $past(enable_pin) && $past(enable_pin, 2)
            && $past(phase_bb_n_pin, 2)) |-> !drive_bb)
        else $error("phase BB driven with its input high");

    a_reset_holds: assert property (@(posedge mclk)
        core_rst |=> (drive_reg == PHASES_OFF) && !fault_n_oe && state_reg == ST_INIT)
        else $error("core not held in reset");

    a_init_state: assert property (@(posedge mclk) disable iff (rst)
        ($fell(core_rst) && enable_pin && !ctrl_drive_off_reg && !fault_hit)
            |=> drive_a && drive_bb && !drive_ab && !drive_b)
        else $error("initial A plus BB excitation missing");

    a_enable_off: assert property (@(posedge mclk) disable iff (rst)
        !enable_pin |=> (drive_reg == PHASES_OFF))
        else $error("outputs not off while enable is low");

    a_fault_pin: assert property (@(posedge mclk) disable iff (core_rst)
        fault_hit |=> fault_n_oe && !fault_n_o)
        else $error("fault pin not pulled low on detection");

    a_fault_latched: assert property (@(posedge mclk) disable iff (core_rst)
        fault_n_oe |-> (drive_reg == PHASES_OFF) ##1 fault_n_oe)
        else $error("fault latch released or outputs driven");

    a_frozen_state: assert property (@(posedge mclk) disable iff (core_rst)
        !enable_pin |=> $stable(state_reg) && $stable(excite_reg)
            && $stable(oc_latch_reg) && $stable(oh_latch_reg))
        else $error("internal state moved while enable is low");

    a_fault_release: assert property (@(posedge mclk)
        (fault_n_oe && !core_rst) |=> fault_n_oe || $past(core_rst))
        else $error("fault pin released without reset");

    // Bus answer and blanking gate checks.
    a_ack_pulse: assert property (@(posedge mclk) disable iff (rst)
        wb_ack_o |=> !wb_ack_o)
        else $error("bus ack held for more than one cycle");

    a_blank_gate: assert property (@(posedge mclk) disable iff (core_rst)
        (enable_pin && overcurrent_det && !blank_open && !oc_latch_reg) |=> !oc_latch_reg)
        else $error("overcurrent latched inside the blanking time");

endmodule
`default_nettype wire

//--- bench/stepper_ctrl_model.sv
// Behavioural sequencing controller that drives the four active-low phase pins.
`timescale 1ns/1ps
`default_nettype none
module stepper_ctrl_model
    import stepper_pkg::*;
(
    input wire logic [3:0] cmd_n,
    output logic phase_a_n,
    output logic phase_ab_n,
    output logic phase_b_n,
    output logic phase_bb_n
);
    // Each command bit steers exactly one pin, so a wiring slip shows up as a wrong output.
    // The bench updates cmd_n just after an edge, so the pins never move on a sampling edge.
    assign phase_a_n = cmd_n[PH_A];
    assign phase_ab_n = cmd_n[PH_AB];
    assign phase_b_n = cmd_n[PH_B];
    assign phase_bb_n = cmd_n[PH_BB];
endmodule
`default_nettype wire

//--- bench/stepper_phase_input_control_tb.sv
// Self-checking testbench of the stepper phase input control block.
`timescale 1ns/1ps
`default_nettype none
module stepper_phase_input_control_tb;
    import stepper_pkg::*;
    logic mclk, rst, cyc, stb, we, srst_n, en, oc, oh, pwm, ack, irq;
    logic d_a, d_ab, d_b, d_bb, f_o, f_oe, pa_n, pab_n, pb_n, pbb_n;
    logic [7:0] adr;
    logic [3:0] sel, cmd_n, drv;
    logic [31:0] dat, dat_o, rd;
    logic [3:0] fixed [7] = '{4'he, 4'hd, 4'hb, 4'h7, 4'hc, 4'h3, 4'h0};
    int n_errors, checks, prev_n, init_st;
    int unsigned seed;

    assign drv = {d_bb, d_b, d_ab, d_a};

    stepper_ctrl_model ctrl (.cmd_n(cmd_n), .phase_a_n(pa_n), .phase_ab_n(pab_n),
        .phase_b_n(pb_n), .phase_bb_n(pbb_n));

    stepper_phase_input_control dut (.mclk(mclk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o),
        .wb_ack_o(ack), .system_reset_n_pin(srst_n), .enable_pin(en), .phase_a_n_pin(pa_n),
        .phase_ab_n_pin(pab_n), .phase_b_n_pin(pb_n), .phase_bb_n_pin(pbb_n),
        .overcurrent_det(oc), .overheat_det(oh), .pwm_cycle_start(pwm), .drive_a(d_a),
        .drive_ab(d_ab), .drive_b(d_b), .drive_bb(d_bb), .fault_n_o(f_o),
        .fault_n_oe(f_oe), .irq(irq));

    // Free-running 40 MHz clock.
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    function automatic int unsigned xorshift();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // Reference drive: active-low requests, and a clashing pair switches both of its phases off.
    function automatic logic [3:0] model_drive(input logic [3:0] pin_n);
        int on;
        on = int'(~pin_n);
        if (on[PH_A] && on[PH_AB]) on &= ~((1 << PH_A) | (1 << PH_AB));
        if (on[PH_B] && on[PH_BB]) on &= ~((1 << PH_B) | (1 << PH_BB));
        return 4'(on);
    endfunction

    task automatic finish_test();
        $display("checks=%0d n_errors=%0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic check_val(input string what, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", what, e, g);
        end
    endtask

    task automatic check_drv(input string what, input logic [3:0] e);
        check_val(what, 32'(e), 32'(drv));
    endtask

    task automatic cyc_n(input int n);
        repeat (n) @(posedge mclk);
    endtask

    // One classic Wishbone cycle; the wait is bounded so a missing ack cannot hang the run.
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
        int n;
        @(posedge mclk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        sel <= 4'h1;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        q = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (ack !== 1'b1) begin
            n_errors++;
            finish_test();
        end else begin
            // One idle edge, so a write has landed before the caller looks.
            @(posedge mclk);
        end
    endtask

    // Apply a pattern and compare after the pin-to-drive latency; the start pattern holds
    // until the first change of the inputs.
    task automatic apply(input logic [3:0] p);
        logic [3:0] e;
        cmd_n <= p;
        cyc_n(5);
        e = (init_st != 0 && int'(p) == prev_n) ? INIT_EXCITE : model_drive(p);
        if (int'(p) != prev_n) init_st = 0;
        prev_n = int'(p);
        check_drv("phase drive", e);
    endtask

    task automatic sys_reset_pulse();
        srst_n <= 1'b0;
        cyc_n(2);
        srst_n <= 1'b1;
        cyc_n(4);
    endtask

    // Main sequence.
    initial begin
        {cyc, stb, we, srst_n, oc, oh, pwm} = '0;
        {adr, sel, dat} = '0;
        rst = 1'b1;
        en = 1'b1;
        cmd_n = 4'hf;
        n_errors = 0;
        checks = 0;
        seed = 79;
        prev_n = 15;
        init_st = 1;
        cyc_n(3);
        rst <= 1'b0;
        cyc_n(3);
        check_drv("drive in system reset", PHASES_OFF);
        srst_n <= 1'b1;
        cyc_n(4);
        check_drv("initial excitation", INIT_EXCITE);
        wb(1'b0, REG_IRQ_MASK, 32'h0, rd);
        check_val("irq mask reset", 32'(IRQ_MASK_RESET), rd);
        wb(1'b0, 8'h10, 32'h0, rd);
        check_val("unmapped read", 32'h0, rd);
        for (int i = 0; i < 24; i++) apply(i < 7 ? fixed[i] : 4'(xorshift()));
        // Outputs off while disabled; new requests and a detector event are ignored.
        en <= 1'b0;
        cmd_n <= 4'hd;
        cyc_n(3);
        check_drv("enable low", PHASES_OFF);
        oh <= 1'b1;
        cyc_n(3);
        check_val("fault while disabled", 32'h0, 32'(f_oe));
        oh <= 1'b0;
        en <= 1'b1;
        apply(4'hd);
        wb(1'b1, REG_CTRL, 32'h1, rd);
        cyc_n(3);
        check_drv("drive off", PHASES_OFF);
        wb(1'b0, REG_STATUS, 32'h0, rd);
        check_val("status", (1 << ST_ENABLE_BIT) | (1 << ST_RUN_BIT), rd);
        wb(1'b1, REG_CTRL, 32'h0, rd);
        cyc_n(3);
        check_drv("drive on", model_drive(4'hd));
        // Overheat latches a fault and raises the interrupt through its mask bit.
        wb(1'b1, REG_IRQ_STATUS, 32'hf, rd);
        wb(1'b1, REG_IRQ_MASK, 32'(1 << EV_OH), rd);
        check_val("irq idle", 32'h0, 32'(irq));
        oh <= 1'b1;
        cyc_n(2);
        oh <= 1'b0;
        cmd_n <= 4'he;
        cyc_n(5);
        check_val("fault enable", 32'h1, 32'(f_oe));
        check_val("fault level", 32'h0, 32'(f_o));
        check_drv("fault drive off", PHASES_OFF);
        check_val("irq raised", 32'h1, 32'(irq));
        wb(1'b1, REG_IRQ_MASK, 32'h0, rd);
        check_val("irq masked", 32'h0, 32'(irq));
        sys_reset_pulse();
        prev_n = 14;
        init_st = 1;
        check_val("fault released", 32'h0, 32'(f_oe));
        check_drv("excitation after reset", INIT_EXCITE);
        wb(1'b1, REG_IRQ_STATUS, 32'hf, rd);
        wb(1'b0, REG_IRQ_STATUS, 32'h0, rd);
        check_val("irq status cleared", 32'h0, rd);
        wb(1'b1, REG_IRQ_MASK, 32'(1 << EV_INIT), rd);
        sys_reset_pulse();
        check_val("irq on reset release", 32'h1, 32'(irq));
        wb(1'b1, REG_IRQ_STATUS, 32'(1 << EV_INIT), rd);
        check_val("irq cleared", 32'h0, 32'(irq));
        // Overcurrent inside the blanking window is ignored, after it the fault latches.
        pwm <= 1'b1;
        cyc_n(1);
        pwm <= 1'b0;
        oc <= 1'b1;
        cyc_n(BLANK_CYCLES - 20);
        check_val("fault in blanking", 32'h0, 32'(f_oe));
        cyc_n(40);
        check_val("fault after blanking", 32'h1, 32'(f_oe));
        oc <= 1'b0;
        wb(1'b0, REG_STATUS, 32'h0, rd);
        check_val("fault status", (1 << ST_OC_BIT) | (1 << ST_ENABLE_BIT) | (1 << ST_FAULT_BIT),
            rd);
        finish_test();
    end
endmodule
`default_nettype wire
